// ===== rtl/alm_map.svh
`ifndef ALM_MAP_SVH
`define ALM_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ALM_CFG_OFS 8'h00
`define ALM_MASK_OFS 8'h06
`define ALM_LIMIT_OFS 8'h07
// ----------------------------------------
// Alert mask register fields
// ----------------------------------------
`define ALM_EN_HI 15
`define ALM_EN_LO 10
`define ALM_B_SHUNT_OVER 15
`define ALM_B_SHUNT_UNDER 14
`define ALM_B_RAIL_OVER 13
`define ALM_B_RAIL_UNDER 12
`define ALM_B_POWER_OVER 11
`define ALM_B_READY_EN 10
`define ALM_B_TRIP 4
`define ALM_B_DONE 3
`define ALM_B_OVF 2
`define ALM_B_POL 1
`define ALM_B_LATCH 0
// ----------------------------------------
// Configuration mode field
// ----------------------------------------
`define ALM_MODE_HI 2
`define ALM_MODE_CONT 2
`define ALM_MODE_MEAS_HI 1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ALM_EN_RST 6'h00
`define ALM_POL_RST 1'b0
`define ALM_LATCH_RST 1'b0
`define ALM_LIMIT_RST 16'h0000
`define ALM_MODE_RST 3'h7
`define ALM_RDATA_RST 16'h0000
`endif

// ===== rtl/alm_pkg.sv
package alm_pkg;
  // ----------------------------------------
  // Register access strobes
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } alm_regbus_t;
  // ----------------------------------------
  // Completed results from the datapath
  // ----------------------------------------
  typedef struct packed {
    logic shunt_done;
    logic rail_done;
    logic power_done;
    logic cycle_done;
    logic overflow;
    logic [15:0] shunt;
    logic [15:0] rail;
    logic [15:0] power;
  } alm_meas_t;
  typedef enum logic [2:0] {
    ALM_SEL_NONE = 3'b000,
    ALM_SEL_SHUNT_OVER = 3'b001,
    ALM_SEL_SHUNT_UNDER = 3'b010,
    ALM_SEL_RAIL_OVER = 3'b011,
    ALM_SEL_RAIL_UNDER = 3'b100,
    ALM_SEL_POWER_OVER = 3'b101
  } alm_sel_t;
  typedef struct packed {
    logic [5:0] enables;
    logic power_over_enable;
    logic len;
    logic [15:0] limit;
    logic [2:0] mode;
    logic trip_flag;
    logic done_flag;
    logic ovf_flag;
    logic ready_hold;
    logic [15:0] rdata;
  } alm_state_t;
  typedef struct packed {
    logic drive;
  } alm_pin_state_t;
endpackage : alm_pkg

// ===== rtl/alm_limit_cmp.sv
`timescale 1ns/1ns
module alm_limit_cmp (
  input logic [4:0] enables,
  input logic [15:0] limit,
  input alm_pkg::alm_meas_t meas,
  output alm_pkg::alm_sel_t sel,
  output logic eval,
  output logic trip
);
  // ----------------------------------------
  // Priority pick, highest enable wins
  // ----------------------------------------
  always_comb begin
    if (enables[4]) begin
      sel = alm_pkg::ALM_SEL_SHUNT_OVER;
    end else if (enables[3]) begin
      sel = alm_pkg::ALM_SEL_SHUNT_UNDER;
    end else if (enables[2]) begin
      sel = alm_pkg::ALM_SEL_RAIL_OVER;
    end else if (enables[1]) begin
      sel = alm_pkg::ALM_SEL_RAIL_UNDER;
    end else if (enables[0]) begin
      sel = alm_pkg::ALM_SEL_POWER_OVER;
    end else begin
      sel = alm_pkg::ALM_SEL_NONE;
    end
  end
  // ----------------------------------------
  // Signed compare on each completed result of the selected function
  // ----------------------------------------
  always_comb begin
    eval = 1'b0;
    trip = 1'b0;
    unique case (sel)
      alm_pkg::ALM_SEL_SHUNT_OVER: begin
        eval = meas.shunt_done;
        trip = meas.shunt_done && ($signed(meas.shunt) > $signed(limit));
      end
      alm_pkg::ALM_SEL_SHUNT_UNDER: begin
        eval = meas.shunt_done;
        trip = meas.shunt_done && ($signed(meas.shunt) < $signed(limit));
      end
      alm_pkg::ALM_SEL_RAIL_OVER: begin
        eval = meas.rail_done;
        trip = meas.rail_done && ($signed(meas.rail) > $signed(limit));
      end
      alm_pkg::ALM_SEL_RAIL_UNDER: begin
        eval = meas.rail_done;
        trip = meas.rail_done && ($signed(meas.rail) < $signed(limit));
      end
      alm_pkg::ALM_SEL_POWER_OVER: begin
        eval = meas.power_done;
        trip = meas.power_done && ($signed(meas.power) > $signed(limit));
      end
      default: begin
        eval = 1'b0;
        trip = 1'b0;
      end
    endcase
  end
endmodule : alm_limit_cmp

// ===== rtl/alm_alert_pin.sv
`timescale 1ns/1ns
module alm_alert_pin (
  input logic clk,
  input logic srst,
  input logic active,
  input logic power_over_enable,
  output logic pin_o,
  output logic pin_oe
);
  alm_pkg::alm_pin_state_t st_r;
  alm_pkg::alm_pin_state_t st_nxt;
  // ----------------------------------------
  // Open collector: only ever pulls low
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.drive = active ^ power_over_enable;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign pin_o = 1'b0;
  assign pin_oe = st_r.drive;
endmodule : alm_alert_pin

// ===== rtl/alm_alert_core.sv
`timescale 1ns/1ns
`include "alm_map.svh"
// Summary of operation
// [R01] Shunt-over enable trips alert when shunt result exceeds the limit.
// [R02] Shunt-under enable trips alert when shunt result falls below the limit.
// [R03] Rail-over enable trips alert when bus result exceeds the limit.
// [R04] Rail-under enable trips alert when bus result falls below the limit.
// [R05] Power-over enable trips alert when power result exceeds the limit.
// [R06] Ready-alert enable asserts alert when the conversion-done flag sets.
// [R07] One limit function watched at a time, ready alert may join it.
// [R08] Several limit enables set: highest-numbered one alone is compared.
// [R09] Sixteen-bit limit register at offset 07h holds the threshold.
// [R10] Limit trip sets the limit-trip flag, distinct from ready alerts.
// [R11] Latched mode clears the limit-trip flag only on a mask register read.
// [R12] Transparent mode clears it after a completed result with no trip.
// [R13] Conversion-done flag sets only when the whole measurement cycle ends.
// [R14] Single-shot: config write, except power-down, clears conversion-done flag.
// [R15] Single-shot: mask register read clears conversion-done flag too.
// [R16] Overflow flag sets when arithmetic overflows, results may be invalid.
// [R17] Polarity bit: 1 active-high, 0 active-low open-collector alert.
// [R18] Latch bit: 1 latched, 0 transparent, transparent after reset.
// [R19] Transparent mode returns alert and flags idle once fault is gone.
// [R20] Latched mode holds alert and flags until host reads mask register.
// [R21] Compare once per completed result, shunt and power taken as signed.
module alm_alert_core (
  input logic clk,
  input logic srst,
  input alm_pkg::alm_regbus_t bus,
  input alm_pkg::alm_meas_t meas,
  output logic [15:0] reg_rdata,
  output logic alert_o,
  output logic alert_oe,
  output logic alert_active
);
  alm_pkg::alm_state_t st_r;
  alm_pkg::alm_state_t st_nxt;
  alm_pkg::alm_sel_t cmp_sel;
  logic mask_rd;
  logic mask_wr;
  logic limit_wr;
  logic cfg_wr;
  logic cfg_clears;
  logic single_shot;
  logic cmp_eval;
  logic cmp_trip;
  logic ready_part;
  logic [15:0] mask_view;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign mask_rd = bus.rd && (bus.addr == `ALM_MASK_OFS);
  assign mask_wr = bus.wr && (bus.addr == `ALM_MASK_OFS);
  assign limit_wr = bus.wr && (bus.addr == `ALM_LIMIT_OFS);
  assign cfg_wr = bus.wr && (bus.addr == `ALM_CFG_OFS);
  assign single_shot = !st_r.mode[`ALM_MODE_CONT];
  // Power-down codes leave the flag alone
  assign cfg_clears = cfg_wr && !bus.wdata[`ALM_MODE_CONT]
    && (bus.wdata[`ALM_MODE_MEAS_HI:0] != 2'h0); // [R14]

  always_comb begin
    mask_view = 16'h0000;
    mask_view[`ALM_EN_HI:`ALM_EN_LO] = st_r.enables;
    mask_view[`ALM_B_TRIP] = st_r.trip_flag;
    mask_view[`ALM_B_DONE] = st_r.done_flag;
    mask_view[`ALM_B_OVF] = st_r.ovf_flag;
    mask_view[`ALM_B_POL] = st_r.power_over_enable;
    mask_view[`ALM_B_LATCH] = st_r.len;
  end

  // ----------------------------------------
  // Limit selection and compare
  // ----------------------------------------
  alm_limit_cmp u_cmp (
    .enables(st_r.enables[5:1]),
    .limit(st_r.limit),
    .meas(meas),
    .sel(cmp_sel),
    .eval(cmp_eval),
    .trip(cmp_trip)
  ); // [R08] [R21]

  // ----------------------------------------
  // Alert sources
  // ----------------------------------------
  // Latched ready alert must outlive a done flag cleared by a config write
  assign ready_part = st_r.len ? st_r.ready_hold
    : (st_r.enables[0] && st_r.done_flag); // [R06]
  assign alert_active = st_r.trip_flag || ready_part; // [R07]

  alm_alert_pin u_pin (
    .clk(clk),
    .srst(srst),
    .active(alert_active),
    .power_over_enable(st_r.power_over_enable),
    .pin_o(alert_o),
    .pin_oe(alert_oe)
  ); // [R17]

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (mask_wr) begin
      st_nxt.enables = bus.wdata[`ALM_EN_HI:`ALM_EN_LO];
      st_nxt.power_over_enable = bus.wdata[`ALM_B_POL];
      st_nxt.len = bus.wdata[`ALM_B_LATCH]; // [R18]
    end
    if (limit_wr) begin
      st_nxt.limit = bus.wdata; // [R09]
    end
    if (cfg_wr) begin
      st_nxt.mode = bus.wdata[`ALM_MODE_HI:0];
    end
    // Limit trip flag; a set in the clear cycle wins
    if (st_r.len) begin
      if (mask_rd) begin
        st_nxt.trip_flag = 1'b0; // [R11] [R20]
      end
    end else if (cmp_eval && !cmp_trip) begin
      st_nxt.trip_flag = 1'b0; // [R12] [R19]
    end
    if (cmp_trip) begin
      st_nxt.trip_flag = 1'b1; // [R01] [R02] [R03] [R04] [R05] [R10]
    end
    // Conversion done flag
    if (cfg_clears || (mask_rd && single_shot)) begin
      st_nxt.done_flag = 1'b0; // [R14] [R15]
    end
    if (meas.cycle_done) begin
      st_nxt.done_flag = 1'b1; // [R13]
    end
    // Overflow flag follows the same latch choice
    if (st_r.len) begin
      if (mask_rd) begin
        st_nxt.ovf_flag = 1'b0; // [R20]
      end
    end else if (meas.cycle_done && !meas.overflow) begin
      st_nxt.ovf_flag = 1'b0; // [R19]
    end
    if (meas.overflow) begin
      st_nxt.ovf_flag = 1'b1; // [R16]
    end
    // Latched copy of the ready alert
    if (mask_rd) begin
      st_nxt.ready_hold = 1'b0; // [R20]
    end
    if (meas.cycle_done && st_r.enables[0]) begin
      st_nxt.ready_hold = 1'b1; // [R06]
    end
    // Read data shows flags as they stood before the read clears them
    if (bus.rd) begin
      if (bus.addr == `ALM_MASK_OFS) begin
        st_nxt.rdata = mask_view;
      end else if (bus.addr == `ALM_LIMIT_OFS) begin
        st_nxt.rdata = st_r.limit;
      end else begin
        st_nxt.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.enables <= `ALM_EN_RST;
      st_r.power_over_enable <= `ALM_POL_RST;
      st_r.len <= `ALM_LATCH_RST; // [R18]
      st_r.limit <= `ALM_LIMIT_RST;
      st_r.mode <= `ALM_MODE_RST;
      st_r.rdata <= `ALM_RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence shunt_over_s;
    meas.shunt_done && st_r.enables[5]
      && ($signed(meas.shunt) > $signed(st_r.limit));
  endsequence
  sequence shunt_under_s;
    meas.shunt_done && !st_r.enables[5] && st_r.enables[4]
      && ($signed(meas.shunt) < $signed(st_r.limit));
  endsequence
  sequence rail_over_s;
    meas.rail_done && (st_r.enables[5:4] == 2'h0) && st_r.enables[3]
      && ($signed(meas.rail) > $signed(st_r.limit));
  endsequence
  sequence rail_under_s;
    meas.rail_done && (st_r.enables[5:3] == 3'h0) && st_r.enables[2]
      && ($signed(meas.rail) < $signed(st_r.limit));
  endsequence
  sequence power_over_s;
    meas.power_done && (st_r.enables[5:2] == 4'h0) && st_r.enables[1]
      && ($signed(meas.power) > $signed(st_r.limit));
  endsequence
  sequence quiet_shunt_s;
    meas.shunt_done && st_r.enables[5] && !st_r.len
      && !($signed(meas.shunt) > $signed(st_r.limit));
  endsequence

  shunt_over_a: assert property (shunt_over_s |=> st_r.trip_flag && alert_active) // [R01]
    else $error("shunt over limit did not trip");
  shunt_under_a: assert property (shunt_under_s |=> st_r.trip_flag) // [R02]
    else $error("shunt under limit did not trip");
  rail_over_a: assert property (rail_over_s |=> st_r.trip_flag) // [R03]
    else $error("rail over limit did not trip");
  rail_under_a: assert property (rail_under_s |=> st_r.trip_flag) // [R04]
    else $error("rail under limit did not trip");
  power_over_a: assert property (power_over_s |=> st_r.trip_flag) // [R05]
    else $error("power over limit did not trip");
  ready_alert_a: assert property ( // [R06]
    meas.cycle_done && st_r.enables[0] && !mask_wr |=> st_r.done_flag && alert_active)
    else $error("ready alert missing after conversion");
  priority_clear_a: assert property ( // [R08]
    quiet_shunt_s ##0 (!meas.rail_done && !meas.power_done) |=> !st_r.trip_flag)
    else $error("lower priority function affected the trip flag");
  latch_hold_a: assert property ( // [R20]
    st_r.len && st_r.trip_flag && !mask_rd |=> st_r.trip_flag [*1] ##1 1'b1)
    else $error("latched trip flag dropped without read");
  read_clear_a: assert property ( // [R11]
    st_r.len && mask_rd && !cmp_trip |=> !st_r.trip_flag)
    else $error("mask read did not clear latched trip flag");
  done_cause_a: assert property ( // [R13]
    $rose(st_r.done_flag) |-> $past(meas.cycle_done))
    else $error("done flag set without finished cycle");
  cfg_clear_a: assert property ( // [R14]
    cfg_clears && !meas.cycle_done |=> !st_r.done_flag)
    else $error("config write did not clear done flag");
  ovf_set_a: assert property (meas.overflow |=> st_r.ovf_flag) // [R16]
    else $error("overflow flag not set");
  pin_sense_a: assert property ( // [R17]
    ##1 alert_oe == ($past(alert_active) ^ $past(st_r.power_over_enable)))
    else $error("alert pin sense wrong");

  // ----------------------------------------
  // Flag set, hold and release
  // ----------------------------------------
  sequence quiet_eval_s;
    cmp_eval && !cmp_trip && !st_r.len;
  endsequence
  sequence clean_cycle_s;
    meas.cycle_done && !meas.overflow && !st_r.len;
  endsequence
  sequence single_read_s;
    mask_rd && single_shot && !meas.cycle_done;
  endsequence
  sequence latched_read_s;
    st_r.len && mask_rd && !(meas.cycle_done && st_r.enables[0]);
  endsequence

  trip_quiet_a: assert property (quiet_eval_s |=> !st_r.trip_flag) // [R12]
    else $error("transparent trip flag not cleared by quiet result");
  trip_cause_a: assert property ( // [R10]
    $rose(st_r.trip_flag) |-> $past(cmp_trip))
    else $error("trip flag set without a limit trip");
  idle_enables_a: assert property ( // [R07]
    st_r.enables[5:1] == 5'h00 |=> !$rose(st_r.trip_flag))
    else $error("trip flag rose with no limit function enabled");
  rail_masked_a: assert property ( // [R08]
    st_r.enables[5] && !st_r.trip_flag && !meas.shunt_done |=> !st_r.trip_flag)
    else $error("lower priority result tripped the alert");
  ovf_clear_a: assert property (clean_cycle_s |=> !st_r.ovf_flag) // [R19]
    else $error("transparent overflow flag not cleared");
  ovf_hold_a: assert property ( // [R20]
    st_r.len && st_r.ovf_flag && !mask_rd |=> st_r.ovf_flag)
    else $error("latched overflow flag dropped without read");
  done_set_a: assert property (meas.cycle_done |=> st_r.done_flag) // [R13]
    else $error("done flag not set after finished cycle");
  done_read_a: assert property (single_read_s |=> !st_r.done_flag) // [R15]
    else $error("single-shot mask read did not clear done flag");
  powerdown_keep_a: assert property ( // [R14]
    cfg_wr && !cfg_clears && st_r.done_flag |=> st_r.done_flag)
    else $error("power-down config write cleared done flag");
  ready_release_a: assert property (latched_read_s |=> !st_r.ready_hold) // [R20]
    else $error("mask read did not release latched ready alert");
  // A mask write may drop the latch, so it is left out here
  ready_hold_a: assert property ( // [R20]
    st_r.len && st_r.ready_hold && !mask_rd && !mask_wr |=> alert_active)
    else $error("latched ready alert dropped without read");

  // ----------------------------------------
  // Register loads
  // ----------------------------------------
  // Checked one cycle on, once the write has landed
  latch_load_a: assert property ( // [R18]
    mask_wr |=> st_r.len == $past(bus.wdata[`ALM_B_LATCH]))
    else $error("latch select not loaded");
  pol_load_a: assert property ( // [R17]
    mask_wr |=> st_r.power_over_enable == $past(bus.wdata[`ALM_B_POL]))
    else $error("polarity select not loaded");
  limit_load_a: assert property ( // [R09]
    limit_wr |=> st_r.limit == $past(bus.wdata))
    else $error("limit register not loaded");
  read_view_a: assert property ( // [R10]
    mask_rd |=> reg_rdata[`ALM_B_TRIP] == $past(st_r.trip_flag))
    else $error("mask read lost the trip flag");
endmodule : alm_alert_core

// ===== sim/alm_host_model.sv
`timescale 1ns/1ns
module alm_host_model (
  input wire logic clk,
  output alm_pkg::alm_regbus_t bus,
  input wire logic [15:0] reg_rdata,
  input wire logic alert_o,
  input wire logic alert_oe,
  output logic alert_level
);
  // ----------------------------------------
  // Alert line with board pull-up
  // ----------------------------------------
  // Released line floats to the pull-up, never to the last driven value
  assign alert_level = alert_oe ? alert_o : 1'b1;

  initial bus = '0;

  // ----------------------------------------
  // Register accesses, one strobe cycle each
  // ----------------------------------------
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : write_reg

  // Mask read is how the host releases a latched alert
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask : read_reg
endmodule : alm_host_model

// ===== sim/alert_limit_mask_logic_tb_top.sv
`timescale 1ns/1ns
`include "alm_map.svh"
module alert_limit_mask_logic_tb_top;
  logic clk;
  logic srst;
  alm_pkg::alm_regbus_t bus;
  alm_pkg::alm_meas_t meas;
  logic [15:0] reg_rdata;
  logic alert_o;
  logic alert_oe;
  logic alert_active;
  logic alert_level;
  logic [15:0] rd;
  int err_count;
  int comparisons;

  alm_alert_core dut (.clk(clk), .srst(srst), .bus(bus), .meas(meas), .reg_rdata(reg_rdata),
    .alert_o(alert_o), .alert_oe(alert_oe), .alert_active(alert_active));
  alm_host_model host (.clk(clk), .bus(bus), .reg_rdata(reg_rdata), .alert_o(alert_o),
    .alert_oe(alert_oe), .alert_level(alert_level));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One result pulse; kind 0 shunt, 1 rail, 2 power, 3 cycle end
  task automatic result(input int kind, input logic [15:0] v, input logic ovr);
    @(posedge clk);
    meas <= {(5'h10 >> kind) | {4'h0, ovr}, v, v, v};
    @(posedge clk);
    meas <= {5'h00, v, v, v};
    repeat (2) @(posedge clk);
    #1;
  endtask : result

  // Pin level judged too, since a wrong sense only shows on the wire
  task automatic alert_is(input logic on, input logic hi_active);
    check({15'h0, alert_active}, {15'h0, on});
    check({15'h0, alert_level}, {15'h0, on ~^ hi_active});
  endtask : alert_is

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd, 16'h0000);
    host.read_reg(`ALM_LIMIT_OFS, rd);
    check(rd, 16'h0000);
    alert_is(1'b0, 1'b0);
    host.write_reg(8'h05, 16'hFFFF);
    host.read_reg(8'h05, rd);
    check(rd, 16'h0000);
  endtask : test_reset

  task automatic test_limits();
    int kind [5] = '{0, 0, 1, 1, 2};
    logic [15:0] lim [5] = '{16'h0100, 16'h0000, 16'h1000, 16'h1000, 16'h7000};
    logic [15:0] bad [5] = '{16'h0101, 16'hFFF0, 16'h1001, 16'h0FFF, 16'h7001};
    logic [15:0] good [5] = '{16'h0100, 16'h0000, 16'h1000, 16'h1000, 16'h8000};
    for (int i = 0; i < 5; i++) begin
      host.write_reg(`ALM_LIMIT_OFS, lim[i]);
      host.write_reg(`ALM_MASK_OFS, 16'h8000 >> i);
      host.read_reg(`ALM_LIMIT_OFS, rd);
      check(rd, lim[i]);
      result(kind[i], bad[i], 1'b0);
      alert_is(1'b1, 1'b0);
      host.read_reg(`ALM_MASK_OFS, rd);
      check(rd, (16'h8000 >> i) | 16'h0010);
      result(kind[i], good[i], 1'b0);
      alert_is(1'b0, 1'b0);
      host.read_reg(`ALM_MASK_OFS, rd);
      check(rd, 16'h8000 >> i);
    end
  endtask : test_limits

  task automatic test_priority();
    host.write_reg(`ALM_LIMIT_OFS, 16'h0100);
    host.write_reg(`ALM_MASK_OFS, 16'hA000);
    result(1, 16'h0200, 1'b0);
    alert_is(1'b0, 1'b0);
    result(0, 16'h0200, 1'b0);
    alert_is(1'b1, 1'b0);
    result(0, 16'h0000, 1'b0);
  endtask : test_priority

  task automatic test_latch();
    host.write_reg(`ALM_MASK_OFS, 16'h8001);
    result(0, 16'h0200, 1'b0);
    alert_is(1'b1, 1'b0);
    result(0, 16'h0000, 1'b0);
    alert_is(1'b1, 1'b0);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd, 16'h8011);
    alert_is(1'b0, 1'b0);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd, 16'h8001);
  endtask : test_latch

  task automatic test_polarity();
    host.write_reg(`ALM_MASK_OFS, 16'h8002);
    settle();
    alert_is(1'b0, 1'b1);
    result(0, 16'h0200, 1'b0);
    alert_is(1'b1, 1'b1);
    result(0, 16'h0000, 1'b0);
    alert_is(1'b0, 1'b1);
  endtask : test_polarity

  // Single-shot mode, where mask reads and config writes other than power-down clear the done flag
  task automatic test_ready();
    host.write_reg(`ALM_CFG_OFS, 16'h0003);
    host.write_reg(`ALM_MASK_OFS, 16'h0400);
    result(0, 16'h0000, 1'b0);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd, 16'h0400);
    result(3, 16'h0000, 1'b0);
    alert_is(1'b1, 1'b0);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd, 16'h0408);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd, 16'h0400);
    alert_is(1'b0, 1'b0);
    result(3, 16'h0000, 1'b0);
    host.write_reg(`ALM_CFG_OFS, 16'h0003);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd, 16'h0400);
    result(3, 16'h0000, 1'b0);
    host.write_reg(`ALM_CFG_OFS, 16'h0000);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd, 16'h0408);
    // Latched ready alert must outlive a done flag cleared by a config write
    host.write_reg(`ALM_MASK_OFS, 16'h0401);
    result(3, 16'h0000, 1'b0);
    alert_is(1'b1, 1'b0);
    host.write_reg(`ALM_CFG_OFS, 16'h0003);
    settle();
    alert_is(1'b1, 1'b0);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd, 16'h0401);
    alert_is(1'b0, 1'b0);
  endtask : test_ready

  task automatic test_overflow();
    host.write_reg(`ALM_CFG_OFS, 16'h0007);
    host.write_reg(`ALM_MASK_OFS, 16'h0000);
    result(3, 16'h0000, 1'b1);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd & 16'h0004, 16'h0004);
    result(3, 16'h0000, 1'b0);
    host.read_reg(`ALM_MASK_OFS, rd);
    check(rd & 16'h0004, 16'h0000);
  endtask : test_overflow

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    srst = 1'b1;
    meas = '0;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    test_reset();
    test_limits();
    test_priority();
    test_latch();
    test_polarity();
    test_ready();
    test_overflow();
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule : alert_limit_mask_logic_tb_top
